/* core/pci_pkg.sv */
// Package with register map, field layout and reset values of the pin change interrupt block.
package pci_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int unsigned PORT_COUNT = 3;
  localparam int unsigned PORT_WIDTH = 8;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] RISE_A_ADDR  = 8'h00;
  localparam logic [7:0] RISE_B_ADDR  = 8'h04;
  localparam logic [7:0] RISE_C_ADDR  = 8'h08;
  localparam logic [7:0] FALL_A_ADDR  = 8'h0c;
  localparam logic [7:0] FALL_B_ADDR  = 8'h10;
  localparam logic [7:0] FALL_C_ADDR  = 8'h14;
  localparam logic [7:0] FLAG_A_ADDR  = 8'h18;
  localparam logic [7:0] FLAG_B_ADDR  = 8'h1c;
  localparam logic [7:0] FLAG_C_ADDR  = 8'h20;
  localparam logic [7:0] CTRL_ADDR    = 8'h24;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h28;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h2c;
  localparam logic [7:0] PIN_ADDR_BASE = 8'h30;

  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int unsigned CTRL_MASTER_EN_BIT = 0;
  localparam int unsigned CTRL_SUMMARY_BIT   = 1;
  localparam int unsigned CTRL_SLEEP_BIT     = 2;

  // Interrupt status layout: bit 0 edge seen, bit 1 wake event.
  localparam int unsigned STAT_WIDTH    = 2;
  localparam int unsigned STAT_EDGE_BIT = 0;
  localparam int unsigned STAT_WAKE_BIT = 1;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0]            ENABLE_RESET = 8'h00;
  localparam logic [7:0]            FLAG_RESET   = 8'h00;
  localparam logic [STAT_WIDTH-1:0] STAT_RESET   = 2'h0;
  localparam logic [STAT_WIDTH-1:0] MASK_RESET   = 2'h0;

endpackage

/* core/pci_top.sv */
// Pin change interrupt controller with APB register slave.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps

// Overview of operation
// - Every pin of all three ports can be set up alone as change detector.
// - Without master enable, edges still set flags and the edge status bit, but raise no change_irq.
// - Rising detector per pin works only while its rising enable bit is set.
// - Falling detector per pin works only while its falling enable bit is set.
// - Both enables set make the pin react to either edge direction.
// - Enabled edge sets the pin flag; requests interrupt if master enabled.
// - Summary flag is high exactly while any pin flag is set.
// - Writing zero to a pin flag clears it.
// - An edge during a flag write leaves that flag set, whatever is written.
// - Enabled edge wakes the device from sleep when master enable is set.
// - Edge during sleep is in the flag register in the same cycle that wake is signalled.
module pci_top (
  // Clock, reset and clock enable
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Port pins and sleep state
  input  wire logic [7:0]  port_a_pins,
  input  wire logic [7:0]  port_b_pins,
  input  wire logic [7:0]  port_c_pins,
  input  wire logic        cpu_asleep,
  // Requests
  output logic             change_irq,
  output logic             wake_req,
  output logic             irq
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef logic [2:0][7:0] pci_bank_type;

  typedef struct packed {
    pci_bank_type                        sync1;
    pci_bank_type                        sync2;
    pci_bank_type                        prev;
    pci_bank_type                        rise_en;
    pci_bank_type                        fall_en;
    pci_bank_type                        flags;
    logic                                master_en;
    logic [pci_pkg::STAT_WIDTH-1:0]      stat;
    logic [pci_pkg::STAT_WIDTH-1:0]      mask;
    logic                                pready;
    logic [31:0]                         prdata;
    logic                                pslverr;
    logic                                change_irq;
    logic                                wake_req;
    logic                                irq;
  } pci_state_type;

  pci_state_type state_ff;
  pci_state_type nxt_state;

  // Decodes a flag, rise or fall register address to its port index, or 3 if none.
  function automatic logic [1:0] port_of(input logic [7:0] addr, input logic [7:0] base);
    logic [1:0] idx;
    idx = 2'h3;
    if (addr == base) begin
      idx = 2'h0;
    end else if (addr == base + 8'h04) begin
      idx = 2'h1;
    end else if (addr == base + 8'h08) begin
      idx = 2'h2;
    end
    return idx;
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic         apb_access;
  logic         wr_en;
  logic         rd_en;
  pci_bank_type edge_hit;
  logic [1:0]   flag_port;
  logic [1:0]   rise_port;
  logic [1:0]   fall_port;

  // Only the first access cycle counts: the registered pready ends it after one wait state.
  assign apb_access = psel && penable && !state_ff.pready;
  assign wr_en      = apb_access && pwrite;
  assign rd_en      = apb_access && !pwrite;
  assign flag_port  = port_of(paddr, pci_pkg::FLAG_A_ADDR);
  assign rise_port  = port_of(paddr, pci_pkg::RISE_A_ADDR);
  assign fall_port  = port_of(paddr, pci_pkg::FALL_A_ADDR);

  // ------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------
  // Each pin compares its synchronised level with last cycle's level.
  genvar gp;
  generate
    for (gp = 0; gp < pci_pkg::PORT_COUNT; gp++) begin : g_port
      assign edge_hit[gp] =
          (state_ff.sync2[gp] & ~state_ff.prev[gp] & state_ff.rise_en[gp])
        | (~state_ff.sync2[gp] & state_ff.prev[gp] & state_ff.fall_en[gp]);
    end
  endgenerate

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic any_edge;
    logic any_flag;
    logic summary;
    any_edge  = 1'b0;
    any_flag  = 1'b0;
    summary   = 1'b0;
    nxt_state = state_ff;
    nxt_state.sync1 = {port_c_pins, port_b_pins, port_a_pins};
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.prev  = state_ff.sync2;
    nxt_state.pready  = apb_access;
    nxt_state.pslverr = 1'b0;
    nxt_state.prdata  = 32'h0000_0000;
    any_edge = |edge_hit;

    if (wr_en) begin
      if (rise_port != 2'h3) begin
        nxt_state.rise_en[rise_port] = pwdata[7:0];
      end else if (fall_port != 2'h3) begin
        nxt_state.fall_en[fall_port] = pwdata[7:0];
      end else if (flag_port != 2'h3) begin
        nxt_state.flags[flag_port] = state_ff.flags[flag_port] & pwdata[7:0];
      end else if (paddr == pci_pkg::CTRL_ADDR) begin
        nxt_state.master_en = pwdata[pci_pkg::CTRL_MASTER_EN_BIT];
      end else if (paddr == pci_pkg::IRQ_MASK_ADDR) begin
        nxt_state.mask = pwdata[pci_pkg::STAT_WIDTH-1:0];
      end else if (paddr != pci_pkg::IRQ_STAT_ADDR) begin
        nxt_state.pslverr = 1'b1;
      end
    end

    if (rd_en) begin
      if (rise_port != 2'h3) begin
        nxt_state.prdata = {24'h00_0000, state_ff.rise_en[rise_port]};
      end else if (fall_port != 2'h3) begin
        nxt_state.prdata = {24'h00_0000, state_ff.fall_en[fall_port]};
      end else if (flag_port != 2'h3) begin
        nxt_state.prdata = {24'h00_0000, state_ff.flags[flag_port]};
      end else if (paddr == pci_pkg::CTRL_ADDR) begin
        nxt_state.prdata[pci_pkg::CTRL_MASTER_EN_BIT] = state_ff.master_en;
        nxt_state.prdata[pci_pkg::CTRL_SUMMARY_BIT]   = |state_ff.flags;
        nxt_state.prdata[pci_pkg::CTRL_SLEEP_BIT]     = cpu_asleep;
      end else if (paddr == pci_pkg::IRQ_STAT_ADDR) begin
        nxt_state.prdata = {30'h0000_0000, state_ff.stat};
        nxt_state.stat   = pci_pkg::STAT_RESET;
      end else if (paddr == pci_pkg::IRQ_MASK_ADDR) begin
        nxt_state.prdata = {30'h0000_0000, state_ff.mask};
      end else begin
        nxt_state.pslverr = 1'b1;
      end
    end

    // Edges are merged after the write so a set always beats a clear.
    nxt_state.flags = nxt_state.flags | edge_hit;
    if (any_edge) begin
      nxt_state.stat[pci_pkg::STAT_EDGE_BIT] = 1'b1;
    end
    if (any_edge && cpu_asleep && state_ff.master_en) begin
      nxt_state.stat[pci_pkg::STAT_WAKE_BIT] = 1'b1;
    end

    any_flag = |nxt_state.flags;
    summary  = any_flag;
    // Registered from the next flag value so the request and summary move together.
    nxt_state.change_irq = summary && nxt_state.master_en;
    // Wake rises with the flag itself, never before it is visible.
    nxt_state.wake_req = cpu_asleep && nxt_state.master_en && summary;
    nxt_state.irq = |(nxt_state.stat & nxt_state.mask);
  end

  // ------------------------------------------------------------
  // Register update
  // ------------------------------------------------------------
  // Reset wins over a low clock enable, so the block always comes up clean.
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff            <= '0;
      state_ff.rise_en    <= {3{pci_pkg::ENABLE_RESET}};
      state_ff.fall_en    <= {3{pci_pkg::ENABLE_RESET}};
      state_ff.flags      <= {3{pci_pkg::FLAG_RESET}};
      state_ff.stat       <= pci_pkg::STAT_RESET;
      state_ff.mask       <= pci_pkg::MASK_RESET;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign pready     = state_ff.pready;
  assign prdata     = state_ff.prdata;
  assign pslverr    = state_ff.pslverr;
  assign change_irq = state_ff.change_irq;
  assign wake_req   = state_ff.wake_req;
  assign irq        = state_ff.irq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset || !clk_en);

  // ------------------------------------------------------------
  // Edge and flag checks
  // ------------------------------------------------------------
  rise_sets_flag_a: assert property (edge_hit[0][0] |=> state_ff.flags[0][0])
    else $error("edge did not set pin flag");
  fall_sets_flag_a: assert property (edge_hit[2][7] |=> state_ff.flags[2][7])
    else $error("edge did not set last pin flag");
  both_edges_a: assert property (state_ff.rise_en[2][3] && state_ff.fall_en[2][3]
      && (state_ff.sync2[2][3] != state_ff.prev[2][3]) |=> state_ff.flags[2][3])
    else $error("dual edge pin missed transition");
  set_beats_clear_a: assert property (wr_en && flag_port == 2'h0 && edge_hit[0][0]
      |=> state_ff.flags[0][0])
    else $error("edge lost during flag write");
  zero_clears_a: assert property (wr_en && flag_port == 2'h1 && !pwdata[2]
      && !edge_hit[1][2] |=> !state_ff.flags[1][2])
    else $error("zero write did not clear flag");
  disabled_ignored_a: assert property (!state_ff.rise_en[0][4]
      && !state_ff.fall_en[0][4] && !state_ff.flags[0][4] && !wr_en
      |=> !state_ff.flags[0][4])
    else $error("disabled pin set its flag");
  flag_needs_edge_a: assert property ($rose(state_ff.flags[0][0])
      |-> $past(edge_hit[0][0]))
    else $error("pin flag rose without an edge");
  sync_delay_a: assert property (##3 $past(clk_en, 1) && $past(clk_en, 2)
      |-> state_ff.prev == $past(state_ff.sync1, 2))
    else $error("synchroniser path wrong");
  rise_write_a: assert property (wr_en && paddr == pci_pkg::RISE_A_ADDR
      |=> state_ff.rise_en[0] == $past(pwdata[7:0]))
    else $error("rising enable write lost");
  fall_write_a: assert property (wr_en && paddr == pci_pkg::FALL_C_ADDR
      |=> state_ff.fall_en[2] == $past(pwdata[7:0]))
    else $error("falling enable write lost");

  // ------------------------------------------------------------
  // Request and status checks
  // ------------------------------------------------------------
  summary_tracks_a: assert property (##1 $past(clk_en)
      |-> change_irq == ((|state_ff.flags) && state_ff.master_en))
    else $error("change request differs from summary and enable");
  no_irq_disabled_a: assert property (!state_ff.master_en |-> !change_irq)
    else $error("change request while master disabled");
  summary_zero_a: assert property (!(|state_ff.flags) |-> !change_irq)
    else $error("change request without any pin flag");
  summary_read_a: assert property (rd_en && paddr == pci_pkg::CTRL_ADDR
      |=> prdata[pci_pkg::CTRL_SUMMARY_BIT] == $past(|state_ff.flags))
    else $error("summary bit differs from pin flags");
  master_write_a: assert property (wr_en && paddr == pci_pkg::CTRL_ADDR
      |=> state_ff.master_en == $past(pwdata[pci_pkg::CTRL_MASTER_EN_BIT]))
    else $error("master enable write lost");
  stat_edge_set_a: assert property ((|edge_hit)
      |=> state_ff.stat[pci_pkg::STAT_EDGE_BIT])
    else $error("edge did not set status");
  stat_read_clear_a: assert property (rd_en && paddr == pci_pkg::IRQ_STAT_ADDR
      && !(|edge_hit) |=> state_ff.stat == pci_pkg::STAT_RESET)
    else $error("status read did not clear");
  irq_level_a: assert property (irq == (|(state_ff.stat & state_ff.mask)))
    else $error("interrupt differs from masked status");
  wake_needs_master_a: assert property (!state_ff.master_en |-> !wake_req)
    else $error("wake while master disabled");
  wake_after_flag_a: assert property ($rose(wake_req) |-> (|state_ff.flags))
    else $error("wake before flag visible");
  wake_on_edge_a: assert property (cpu_asleep && state_ff.master_en && (|edge_hit)
      ##1 cpu_asleep && state_ff.master_en |-> wake_req)
    else $error("asleep edge did not wake");
  wake_event_a: assert property ((|edge_hit) && cpu_asleep && state_ff.master_en
      |=> state_ff.stat[pci_pkg::STAT_WAKE_BIT])
    else $error("asleep edge did not set wake status");

  // ------------------------------------------------------------
  // Bus and clock enable checks
  // ------------------------------------------------------------
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  // A low clock enable holds the synchroniser too, so short pin pulses then go unseen.
  freeze_hold_a: assert property (@(posedge mclk) disable iff (reset)
      !clk_en |=> $stable(state_ff))
    else $error("state moved while clock enable low");

  // ------------------------------------------------------------
  // Covers
  // ------------------------------------------------------------
  cov_wake_c: cover property (cpu_asleep ##1 wake_req);
  cov_clear_race_c: cover property (wr_en && flag_port != 2'h3 && (|edge_hit));
  cov_irq_c: cover property (!change_irq ##1 change_irq);
  cov_dual_edge_c: cover property (state_ff.rise_en[2][3] && edge_hit[2][3] && state_ff.prev[2][3]);
  cov_stat_clear_c: cover property (rd_en && paddr == pci_pkg::IRQ_STAT_ADDR);

endmodule

/* bench/pci_pin_model.sv */
// Model of the external signals on the three port pin groups.
`timescale 1ns/1ps
module pci_pin_model (
  // Clock and commanded levels
  input  wire logic        mclk,
  input  wire logic [23:0] level,
  // Pin groups
  output logic [7:0]       pins_a,
  output logic [7:0]       pins_b,
  output logic [7:0]       pins_c
);
  // Pins move only after an edge, so no level is shorter than one cycle.
  initial {pins_c, pins_b, pins_a} = 24'h0;
  always @(posedge mclk) begin
    {pins_c, pins_b, pins_a} <= level;
  end
endmodule

/* bench/test_pci_top.sv */
// Self-checking testbench of the pin change interrupt block.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module test_pci_top;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        asleep = 1'b0;
  logic        clk_en = 1'b1;
  logic [23:0] level = 24'h0;
  logic        pready, pslverr, change_irq, wake_req, irq;
  logic [31:0] prdata, rdat, seed;
  logic [7:0]  pa, pb, pc, rise [3], fall [3], exp [3];
  logic        rerr;
  logic [23:0] nxt;
  int          n_fail = 0;
  int          comparisons = 0;
  always #2.5 mclk = ~mclk;
  pci_pin_model PINS (.mclk(mclk), .level(level), .pins_a(pa), .pins_b(pb), .pins_c(pc));
  pci_top DUT (.mclk(mclk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc),
    .cpu_asleep(asleep), .change_irq(change_irq), .wake_req(wake_req), .irq(irq));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] hits(input logic [7:0] o, n, r, f);
    return (r & ~o & n) | (f & o & ~n);
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    if (n >= 50) begin
      n_fail++;
      $display("mismatch at %0t: no ready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    seed = 32'h5ff1;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    rd(pci_pkg::FLAG_A_ADDR);
    `CHK(rdat, 32'h0)
    rd(8'hfc);
    `CHK({rerr, rdat}, 33'h100000000)
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      rise[k] = (k == 2) ? 8'hff : seed[7:0];
      fall[k] = (k == 2) ? 8'hff : seed[15:8];
      exp[k] = 8'h00;
      wr(pci_pkg::RISE_A_ADDR + 8'(4 * k), {24'h0, rise[k]});
      wr(pci_pkg::FALL_A_ADDR + 8'(4 * k), {24'h0, fall[k]});
    end
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      nxt = level ^ seed[23:0];
      for (int k = 0; k < 3; k++) exp[k] |= hits(level[8*k+:8], nxt[8*k+:8], rise[k], fall[k]);
      level <= nxt;
      repeat (6) @(posedge mclk);
      `CHK(change_irq, 1'b0)
      rd(pci_pkg::FLAG_A_ADDR + 8'(4 * (i % 3)));
      `CHK(rdat[7:0], exp[i % 3])
    end
    $display("test random edges done");
    rd(pci_pkg::CTRL_ADDR);
    `CHK(rdat[1], |{exp[0], exp[1], exp[2]})
    wr(pci_pkg::CTRL_ADDR, 32'h1);
    wr(pci_pkg::IRQ_MASK_ADDR, 32'h1);
    `CHK({change_irq, irq}, 2'b11)
    rd(pci_pkg::IRQ_STAT_ADDR);
    `CHK(rdat[0], 1'b1)
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    for (int k = 0; k < 3; k++) begin
      rd(pci_pkg::FLAG_A_ADDR + 8'(4 * k));
      wr(pci_pkg::FLAG_A_ADDR + 8'(4 * k), rdat ^ 32'hff);
      rd(pci_pkg::FLAG_A_ADDR + 8'(4 * k));
      `CHK(rdat, 32'h0)
    end
    rd(pci_pkg::CTRL_ADDR);
    `CHK({change_irq, rdat[1]}, 2'b00)
    $display("test clear done");
    wr(pci_pkg::RISE_A_ADDR, 32'h1);
    wr(pci_pkg::FALL_A_ADDR, 32'h0);
    level[0] <= 1'b0;
    repeat (6) @(posedge mclk);
    wr(pci_pkg::FLAG_A_ADDR, 32'h0);
    level[0] <= 1'b1;
    @(posedge mclk);
    wr(pci_pkg::FLAG_A_ADDR, 32'h0);
    rd(pci_pkg::FLAG_A_ADDR);
    `CHK(rdat, 32'h1)
    wr(pci_pkg::FLAG_A_ADDR, 32'h0);
    level[0] <= 1'b0;
    asleep <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK(wake_req, 1'b0)
    level[0] <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK(wake_req, 1'b1)
    rd(pci_pkg::FLAG_A_ADDR);
    `CHK(rdat, 32'h1)
    rd(pci_pkg::CTRL_ADDR);
    `CHK(rdat[2:0], 3'b111)
    rd(pci_pkg::IRQ_STAT_ADDR);
    `CHK(rdat[1], 1'b1)
    wr(pci_pkg::CTRL_ADDR, 32'h0);
    repeat (2) @(posedge mclk);
    `CHK({wake_req, change_irq}, 2'b00)
    $display("test sleep done");
    wr(pci_pkg::FLAG_A_ADDR, 32'h0);
    wr(pci_pkg::CTRL_ADDR, 32'h1);
    level[0] <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK(change_irq, 1'b0)
    clk_en <= 1'b0;
    level[0] <= 1'b1;
    repeat (8) @(posedge mclk);
    `CHK(change_irq, 1'b0)
    clk_en <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK(change_irq, 1'b1)
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    `CHK({change_irq, wake_req, irq}, 3'b000)
    rd(pci_pkg::FLAG_A_ADDR);
    `CHK(rdat, 32'h0)
    $display("test enable and reset done");
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    $display("mismatch at %0t: watchdog", $time);
    finish_test;
  end
endmodule
